//--- dv/synth_ctl_checker.sv
// Port-level checks for the synthesizer power-down and mode control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module synth_ctl_checker (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_load_strobe,
   input wire logic o_aux_pump_up,
   input wire logic o_aux_pump_dn,
   input wire logic o_aux_pump_hiz,
   input wire logic [2:0] o_aux_pump_current,
   input wire logic o_main_pump_up,
   input wire logic o_main_pump_dn,
   input wire logic o_main_pump_hiz,
   input wire logic [2:0] o_main_pump_current,
   input wire logic o_aux_loop_sleep,
   input wire logic o_main_loop_sleep,
   input wire logic o_osc_buf_en,
   input wire logic o_mfo_out,
   input wire logic o_mfo_oe
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   // Buffer follows the two sleep flags
   osc_buf_a: assert property (o_osc_buf_en == !(o_aux_loop_sleep && o_main_loop_sleep))
      else $error("oscillator buffer state wrong");
   // Current code is 1 or 4 units on both pumps
   pump_code_a: assert property ((o_aux_pump_current inside {3'h1, 3'h4}) &&
      (o_main_pump_current inside {3'h1, 3'h4})) else $error("pump current code wrong");
   aux_hiz_quiet_a: assert property (o_aux_pump_hiz [*2] |-> !o_aux_pump_up && !o_aux_pump_dn)
      else $error("aux pump pulses while high impedance");
   aux_sleep_quiet_a: assert property (o_aux_loop_sleep [*3] |-> !o_aux_pump_up && !o_aux_pump_dn)
      else $error("aux pump pulses while asleep");
   main_sleep_quiet_a: assert property ($rose(o_main_loop_sleep) |=>
      (!o_main_pump_up && !o_main_pump_dn) [*4]) else $error("main pump pulses after sleep");
   reset_state_a: assert property ($fell(i_srst) |-> o_osc_buf_en && o_aux_pump_hiz &&
      o_main_pump_hiz && !o_mfo_oe && !o_aux_loop_sleep) else $error("reset state wrong");
   // Aux gain only moves a few cycles after a strobe
   gain_load_a: assert property ($changed(o_aux_pump_current) |->
      $past(i_load_strobe, 2) || $past(i_load_strobe, 3)) else $error("gain moved without load");
   async_sleep_a: assert property ($rose(o_aux_loop_sleep) && o_aux_pump_hiz |->
      $past(i_load_strobe, 2) || $past(i_load_strobe, 3)) else $error("async sleep late");
   // Main scenarios reached
   cover property ($rose(o_aux_loop_sleep));
   cover property (!o_osc_buf_en);
   cover property (o_mfo_oe && !o_mfo_out);
endmodule : synth_ctl_checker
bind synth_ctl synth_ctl_checker i_synth_ctl_checker (.i_clk, .i_srst, .i_load_strobe,
   .o_aux_pump_up, .o_aux_pump_dn, .o_aux_pump_hiz, .o_aux_pump_current, .o_main_pump_up,
   .o_main_pump_dn, .o_main_pump_hiz, .o_main_pump_current, .o_aux_loop_sleep,
   .o_main_loop_sleep, .o_osc_buf_en, .o_mfo_out, .o_mfo_oe);

//--- dv/synth_host.sv
// Host model: shifts 22-bit words into the serial port and raises the strobe.
// Assumes i_clk is the bench clock; one link period is 13 of its cycles.
`timescale 1ns/1ps
module synth_host (
   input wire logic i_clk,
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_load_strobe
);
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_load_strobe = 1'b0;
   end
   // Most significant bit first; link clock rests low between frames
   task automatic send(input logic [synth_ctl_pkg::WORD_W-1:0] word);
      for (int i = synth_ctl_pkg::WORD_W - 1; i >= 0; i--) begin
         o_ser_data <= word[i];
         repeat (6) @(posedge i_clk);
         o_ser_clk <= 1'b1;
         repeat (7) @(posedge i_clk);
         o_ser_clk <= 1'b0;
      end
      o_ser_data <= ~word[0]; // Released line shows the inverse
      repeat (6) @(posedge i_clk);
      o_load_strobe <= 1'b1;
      repeat (7) @(posedge i_clk);
      o_load_strobe <= 1'b0;
   endtask : send
endmodule : synth_host

//--- dv/testbench.sv
// Self-checking bench for the synthesizer power-down and mode control.
// Assumes the host model drives the serial pins; oscillator and VCO pins run free.
`timescale 1ns/1ps
module testbench;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_osc = 1'b0;
   logic i_aux_vco = 1'b0;
   logic i_main_vco = 1'b0;
   logic ser_clk, ser_data, load_strobe, aux_up, aux_dn, aux_hiz, main_up, main_dn, main_hiz;
   logic aux_sleep, main_sleep, osc_en, mfo_out, mfo_oe;
   logic [2:0] aux_cur, main_cur;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   always #2.5 i_clk = ~i_clk;
   synth_host i_synth_host (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
      .o_load_strobe(load_strobe));
   synth_ctl i_synth_ctl (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_ser_clk(ser_clk),
      .i_ser_data(ser_data), .i_load_strobe(load_strobe), .i_osc(i_osc),
      .i_aux_vco(i_aux_vco), .i_main_vco(i_main_vco), .o_aux_pump_up(aux_up),
      .o_aux_pump_dn(aux_dn), .o_aux_pump_hiz(aux_hiz), .o_aux_pump_current(aux_cur),
      .o_main_pump_up(main_up), .o_main_pump_dn(main_dn), .o_main_pump_hiz(main_hiz),
      .o_main_pump_current(main_cur), .o_aux_loop_sleep(aux_sleep),
      .o_main_loop_sleep(main_sleep), .o_osc_buf_en(osc_en), .o_mfo_out(mfo_out),
      .o_mfo_oe(mfo_oe));
   // Free-running reference and VCO pins, plus the hang limit
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_osc <= cyc[4];
      i_aux_vco <= cyc[2];
      i_main_vco <= cyc[3];
      if (cyc == 60000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Mode bits {sel hi, sel lo, hiz, gain, polarity} over a ratio of 6
   function automatic logic [19:0] rw(input logic [4:0] m);
      return {m, 15'h0006};
   endfunction : rw
   // Feedback word: prescaler 16, B of 3, A of 0
   function automatic logic [19:0] nw(input logic sleep);
      return {sleep, 1'b0, 13'h0003, 5'h00};
   endfunction : nw
   task automatic wr(input logic [1:0] addr, input logic [19:0] data);
      i_synth_host.send({data, addr});
      repeat (8) @(posedge i_clk);
   endtask : wr
   task automatic t_pump_modes();
      logic [1:0] a;
      for (int l = 0; l < 2; l++) begin
         a = l ? synth_ctl_pkg::ADDR_MAIN_R : synth_ctl_pkg::ADDR_AUX_R;
         wr(a, rw(5'h03));
         check("current high", 3'h4, l ? main_cur : aux_cur);
         check("hiz off", 3'h0, {2'b0, l ? main_hiz : aux_hiz});
         wr(a, rw(5'h04));
         check("current low", 3'h1, l ? main_cur : aux_cur);
         check("hiz on", 3'h1, {2'b0, l ? main_hiz : aux_hiz});
      end
      $display("test pump_modes done");
   endtask : t_pump_modes
   task automatic t_sleep();
      wr(synth_ctl_pkg::ADDR_AUX_N, nw(1'b1));
      check("aux asleep", 3'h1, {2'b0, aux_sleep});
      check("buffer on", 3'h1, {2'b0, osc_en});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h00));
      wr(synth_ctl_pkg::ADDR_MAIN_N, nw(1'b1));
      for (int i = 0; i < 1000 && main_sleep !== 1'b1; i++) @(posedge i_clk);
      check("main asleep", 3'h1, {2'b0, main_sleep});
      check("buffer off", 3'h0, {2'b0, osc_en});
      wr(synth_ctl_pkg::ADDR_AUX_N, nw(1'b0));
      check("aux awake", 3'h0, {2'b0, aux_sleep});
      check("buffer back", 3'h1, {2'b0, osc_en});
      wr(synth_ctl_pkg::ADDR_MAIN_N, nw(1'b0));
      check("main awake", 3'h0, {2'b0, main_sleep});
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_mfo();
      check("pin off", 3'h0, {2'b0, mfo_oe});
      wr(synth_ctl_pkg::ADDR_AUX_R, rw(5'h10));
      check("divider drive", 3'h1, {2'b0, mfo_oe});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h12));
      check("fast pull", 3'h2, {1'b0, mfo_oe, mfo_out});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h10));
      check("fast idle", 3'h0, {2'b0, mfo_oe});
      wr(synth_ctl_pkg::ADDR_AUX_R, rw(5'h18));
      check("aux reset", 3'h2, {1'b0, aux_hiz, main_hiz});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h18));
      check("all reset", 3'h3, {1'b0, aux_hiz, main_hiz});
      wr(synth_ctl_pkg::ADDR_AUX_R, rw(5'h00));
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h00));
      check("reset removed", 3'h0, {mfo_oe, aux_hiz, main_hiz});
      $display("test mfo done");
   endtask : t_mfo
   // Lock modes pull low while unlocked; main divider mode drives
   task automatic t_lock_detect();
      wr(synth_ctl_pkg::ADDR_AUX_R, rw(5'h08));
      check("aux lock pull", 3'h2, {1'b0, mfo_oe, mfo_out});
      for (int i = 0; i < 800 && aux_dn !== 1'b1; i++) @(posedge i_clk);
      check("polarity swap", 3'h1, {1'b0, aux_up, aux_dn});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h08));
      check("both lock pull", 3'h2, {1'b0, mfo_oe, mfo_out});
      wr(synth_ctl_pkg::ADDR_MAIN_R, rw(5'h10));
      check("main divider drive", 3'h1, {2'b0, mfo_oe});
      $display("test lock_detect done");
   endtask : t_lock_detect
   initial begin
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      t_pump_modes();
      t_sleep();
      t_mfo();
      t_lock_detect();
      summarize();
   end
endmodule : testbench

//--- logic/synth_ctl.sv
// Power-down sequencing, pump mode bits and output pin selector for a
// two-loop frequency synthesizer, with its serial load port.
// Assumes serial clock, data, strobe, reference and prescaler inputs
// are asynchronous pins, each slow against i_clk.
//
// How it works
// - Sleeping loop holds its counters in reset
// - Counters restart from zero on wake
// - Pump low-Z: sleep after pump pulse ends
// - Pump high-Z: sleep at once
// - Oscillator buffer off only when both sleep
// - Mode bits are R-word bits 15 to 19
// - High-Z bit and 1X/4X gain select
// - Low pump current is quarter of high
// - Serial port and latches work while sleeping
// - Selector zero disables, else lock detect
// - Lock shows high with narrow low pulses
// - One high selector bit shows divider output
// - Both high, low clear: fast acquisition pull
// - Aux counter reset forces aux high-Z
// - Main counter reset forces main high-Z; all reset, both
// - Counters resume together after reset mode
// - 22-bit word latched on strobe rise
// - Sleep bit is N-word bit 19
`timescale 1ns/1ps
module synth_ctl (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_load_strobe,
   input wire logic i_osc,
   input wire logic i_aux_vco,
   input wire logic i_main_vco,
   output logic o_aux_pump_up,
   output logic o_aux_pump_dn,
   output logic o_aux_pump_hiz,
   output logic [2:0] o_aux_pump_current,
   output logic o_main_pump_up,
   output logic o_main_pump_dn,
   output logic o_main_pump_hiz,
   output logic [2:0] o_main_pump_current,
   output logic o_aux_loop_sleep,
   output logic o_main_loop_sleep,
   output logic o_osc_buf_en,
   output logic o_mfo_out,
   output logic o_mfo_oe
);

   // Whole module state
   typedef struct packed {
      // Pin synchronisers
      logic [2:0] sclk_s;
      logic [1:0] sdat_s;
      logic [2:0] le_s;
      logic [2:0] osc_s;
      logic [1:0][2:0] vco_s;

      // Serial port and latched words
      logic [synth_ctl_pkg::WORD_W-1:0] shift;
      logic [1:0][synth_ctl_pkg::DATA_W-1:0] r_word;
      logic [1:0][synth_ctl_pkg::DATA_W-1:0] n_word;

      // Dividers, phase detector and lock state
      logic [1:0][synth_ctl_pkg::R_RATIO_W-1:0] r_cnt;
      logic [1:0][synth_ctl_pkg::N_RATIO_W-1:0] n_cnt;
      logic [1:0] r_tick;
      logic [1:0] n_tick;
      logic [1:0] up;
      logic [1:0] dn;
      logic [1:0][synth_ctl_pkg::LOCK_W-1:0] pulse_len;
      logic [1:0] locked;

      // Sleep flags and registered outputs
      logic [1:0] asleep;
      logic [1:0] pump_up;
      logic [1:0] pump_dn;
      logic [1:0] pump_hiz;
      logic [1:0][2:0] pump_current;
      logic osc_buf_en;
      logic mfo_out;
      logic mfo_oe;
   } state_t;

   state_t st;
   state_t next_st;

   // Combinational helpers per loop
   logic [1:0] sel_lo;
   logic [1:0] sel_hi;
   logic [1:0] cnt_reset;
   logic [1:0] hold;
   logic [1:0] pumping;

   // Edge finders and divider ratios
   logic [1:0] osc_edge;
   logic [1:0] vco_edge;
   logic [1:0][synth_ctl_pkg::N_RATIO_W-1:0] n_ratio;
   logic [1:0][synth_ctl_pkg::R_RATIO_W-1:0] r_ratio;

   // Serial edges and lock view
   logic sclk_rise;
   logic le_rise;
   logic lock_all;
   logic lock_pulse;

   // Mode decode shared by the next-state logic
   always_comb begin
      sclk_rise = st.sclk_s[1] & ~st.sclk_s[2];
      le_rise = st.le_s[1] & ~st.le_s[2];
      for (int i = 0; i < 2; i++) begin
         // Selector bits: aux holds sel 0/1, main holds sel 2/3
         sel_lo[i] = st.r_word[i][synth_ctl_pkg::BIT_SEL_LO];
         sel_hi[i] = st.r_word[i][synth_ctl_pkg::BIT_SEL_HI];
         pumping[i] = st.up[i] | st.dn[i];
         osc_edge[i] = st.osc_s[1] & ~st.osc_s[2];
         vco_edge[i] = st.vco_s[i][1] & ~st.vco_s[i][2];
         r_ratio[i] = st.r_word[i][synth_ctl_pkg::R_RATIO_W-1:0];
      end
      // Counter reset modes need both high selector bits
      for (int i = 0; i < 2; i++) begin
         cnt_reset[i] = sel_hi[synth_ctl_pkg::AUX] & sel_hi[synth_ctl_pkg::MAIN]
                        & sel_lo[i];
         hold[i] = st.asleep[i] | cnt_reset[i];
      end
      // Feedback ratio is P times B plus A
      for (int i = 0; i < 2; i++) begin
         // Prescaler select picks the larger or smaller modulus shift
         if (st.n_word[i][synth_ctl_pkg::BIT_PRESCALE]) begin
            n_ratio[i] = synth_ctl_pkg::N_RATIO_W'(
               st.n_word[i][synth_ctl_pkg::B_LSB +: synth_ctl_pkg::B_W])
               << synth_ctl_pkg::P_SHIFT_HI;
         end else begin
            n_ratio[i] = synth_ctl_pkg::N_RATIO_W'(
               st.n_word[i][synth_ctl_pkg::B_LSB +: synth_ctl_pkg::B_W])
               << synth_ctl_pkg::P_SHIFT_LO;
         end
         // Swallow count rides on top of the modulus product
         n_ratio[i] = n_ratio[i] + synth_ctl_pkg::N_RATIO_W'(
            st.n_word[i][synth_ctl_pkg::A_LSB +: synth_ctl_pkg::A_W]);
      end
      // Lock detect view over the loops the low selector bits pick
      lock_all = (~sel_lo[synth_ctl_pkg::AUX] | st.locked[synth_ctl_pkg::AUX])
                 & (~sel_lo[synth_ctl_pkg::MAIN] | st.locked[synth_ctl_pkg::MAIN]);
      lock_pulse = (sel_lo[synth_ctl_pkg::AUX] & pumping[synth_ctl_pkg::AUX])
                   | (sel_lo[synth_ctl_pkg::MAIN] & pumping[synth_ctl_pkg::MAIN]);
   end

   // Next-state logic
   always_comb begin
      next_st = st;

      // Two-flop synchronisers, third flop only for edge finding
      // Only stages 1 and 2 feed logic; stage 0 may still be settling
      next_st.sclk_s = {st.sclk_s[1:0], i_ser_clk};
      next_st.sdat_s = {st.sdat_s[0], i_ser_data};
      next_st.le_s = {st.le_s[1:0], i_load_strobe};
      next_st.osc_s = {st.osc_s[1:0], i_osc};
      next_st.vco_s[synth_ctl_pkg::AUX] = {st.vco_s[synth_ctl_pkg::AUX][1:0], i_aux_vco};
      next_st.vco_s[synth_ctl_pkg::MAIN] = {st.vco_s[synth_ctl_pkg::MAIN][1:0], i_main_vco};

      // Serial shift, MSB first, never gated by sleep
      // Surplus leading bits drop off the top; the last 22 count
      if (sclk_rise) begin
         next_st.shift = {st.shift[synth_ctl_pkg::WORD_W-2:0], st.sdat_s[1]};
      end

      // Strobe rise moves the data field to the addressed latch
      // Address field is the two bits shifted in last
      if (le_rise) begin
         unique case (st.shift[synth_ctl_pkg::ADDR_W-1:0])
            synth_ctl_pkg::ADDR_AUX_R: begin
               next_st.r_word[synth_ctl_pkg::AUX] =
                  st.shift[synth_ctl_pkg::WORD_W-1:synth_ctl_pkg::ADDR_W];
            end
            synth_ctl_pkg::ADDR_AUX_N: begin
               next_st.n_word[synth_ctl_pkg::AUX] =
                  st.shift[synth_ctl_pkg::WORD_W-1:synth_ctl_pkg::ADDR_W];
            end
            synth_ctl_pkg::ADDR_MAIN_R: begin
               next_st.r_word[synth_ctl_pkg::MAIN] =
                  st.shift[synth_ctl_pkg::WORD_W-1:synth_ctl_pkg::ADDR_W];
            end
            synth_ctl_pkg::ADDR_MAIN_N: begin
               next_st.n_word[synth_ctl_pkg::MAIN] =
                  st.shift[synth_ctl_pkg::WORD_W-1:synth_ctl_pkg::ADDR_W];
            end
         endcase
      end

      for (int i = 0; i < 2; i++) begin
         // Reference and feedback dividers, held at zero while idle
         // Both restart from zero together, so R and N stay in step
         next_st.r_tick[i] = 1'b0;
         next_st.n_tick[i] = 1'b0;
         if (hold[i]) begin
            next_st.r_cnt[i] = '0;
            next_st.n_cnt[i] = '0;
         end else begin
            if (osc_edge[i]) begin
               if (st.r_cnt[i] >= r_ratio[i] - 15'h0001) begin
                  next_st.r_cnt[i] = '0;
                  next_st.r_tick[i] = 1'b1;
               end else begin
                  next_st.r_cnt[i] = st.r_cnt[i] + 15'h0001;
               end
            end
            if (vco_edge[i]) begin
               if (st.n_cnt[i] >= n_ratio[i] - 18'h00001) begin
                  next_st.n_cnt[i] = '0;
                  next_st.n_tick[i] = 1'b1;
               end else begin
                  next_st.n_cnt[i] = st.n_cnt[i] + 18'h00001;
               end
            end
         end

         // Phase detector: a pulse runs from one tick to the other
         // Coincident ticks cancel, so an aligned loop shows no pulse
         if (hold[i]) begin
            next_st.up[i] = 1'b0;
            next_st.dn[i] = 1'b0;
         end else if ((st.up[i] | st.r_tick[i]) & (st.dn[i] | st.n_tick[i])) begin
            next_st.up[i] = 1'b0;
            next_st.dn[i] = 1'b0;
         end else begin
            next_st.up[i] = st.up[i] | st.r_tick[i];
            next_st.dn[i] = st.dn[i] | st.n_tick[i];
         end

         // Pulse width measure decides lock at each pulse end
         // Count saturates so very long pulses cannot wrap into lock
         if (pumping[i]) begin
            if (st.pulse_len[i] != synth_ctl_pkg::LEN_MAX) begin
               next_st.pulse_len[i] = st.pulse_len[i] + 4'h1;
            end
            if (st.pulse_len[i] > synth_ctl_pkg::LOCK_CYC) begin
               next_st.locked[i] = 1'b0;
            end
         end else begin
            next_st.pulse_len[i] = '0;
         end
         if (pumping[i] & ~(next_st.up[i] | next_st.dn[i])) begin
            next_st.locked[i] = (st.pulse_len[i] <= synth_ctl_pkg::LOCK_CYC);
         end
         if (hold[i]) begin
            next_st.locked[i] = 1'b0;
         end

         // Sleep entry, taken only from the latched words
         // A half-shifted word never reaches here, so no false sleep
         if (!st.n_word[i][synth_ctl_pkg::BIT_SLEEP]) begin
            next_st.asleep[i] = 1'b0;
         end else if (st.r_word[i][synth_ctl_pkg::BIT_HIZ]) begin
            next_st.asleep[i] = 1'b1;
         end else if (!pumping[i]) begin
            next_st.asleep[i] = 1'b1;
         end

         // Pump drive; polarity high means reference lead pumps up
         // Sleep and counter-reset modes force high impedance as well
         next_st.pump_hiz[i] = st.r_word[i][synth_ctl_pkg::BIT_HIZ] | hold[i];
         if (next_st.pump_hiz[i]) begin
            next_st.pump_up[i] = 1'b0;
            next_st.pump_dn[i] = 1'b0;
         end else if (st.r_word[i][synth_ctl_pkg::BIT_POLARITY]) begin
            next_st.pump_up[i] = st.up[i];
            next_st.pump_dn[i] = st.dn[i];
         end else begin
            next_st.pump_up[i] = st.dn[i];
            next_st.pump_dn[i] = st.up[i];
         end
         // Gain bit picks the 4X or the quarter-size 1X current
         if (st.r_word[i][synth_ctl_pkg::BIT_GAIN]) begin
            next_st.pump_current[i] = synth_ctl_pkg::PUMP_HIGH;
         end else begin
            next_st.pump_current[i] = synth_ctl_pkg::PUMP_LOW;
         end
      end

      // Oscillator buffer stays on while any loop runs
      // Next-state flags keep it in step with the sleep outputs
      next_st.osc_buf_en = ~(next_st.asleep[synth_ctl_pkg::AUX]
                             & next_st.asleep[synth_ctl_pkg::MAIN]);

      // Multifunction pin: open drain pulls low when enabled
      // Divider modes drive the tick; other modes only pull low
      next_st.mfo_out = 1'b0;
      next_st.mfo_oe = 1'b0;
      unique case ({sel_hi[synth_ctl_pkg::MAIN], sel_hi[synth_ctl_pkg::AUX]})
         2'b00: begin
            if (sel_lo[synth_ctl_pkg::AUX] | sel_lo[synth_ctl_pkg::MAIN]) begin
               next_st.mfo_oe = ~lock_all | lock_pulse;
            end
         end
         2'b01: begin
            next_st.mfo_oe = 1'b1;
            next_st.mfo_out = sel_lo[synth_ctl_pkg::AUX] ?
               st.n_tick[synth_ctl_pkg::AUX] : st.r_tick[synth_ctl_pkg::AUX];
         end
         2'b10: begin
            next_st.mfo_oe = 1'b1;
            next_st.mfo_out = sel_lo[synth_ctl_pkg::AUX] ?
               st.n_tick[synth_ctl_pkg::MAIN] : st.r_tick[synth_ctl_pkg::MAIN];
         end
         2'b11: begin
            if (~sel_lo[synth_ctl_pkg::AUX] & ~sel_lo[synth_ctl_pkg::MAIN]) begin
               // Damping resistor grounded while main gain is high
               next_st.mfo_oe = st.r_word[synth_ctl_pkg::MAIN][synth_ctl_pkg::BIT_GAIN];
            end else begin
               // Counter-reset modes leave the pin released
               next_st.mfo_oe = 1'b0;
            end
         end
      endcase
   end

   // State register with clock enable and synchronous reset
   // Pumps start high impedance until the words are decoded
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st <= '0;
         st.r_word <= {synth_ctl_pkg::WORD_RESET, synth_ctl_pkg::WORD_RESET};
         st.n_word <= {synth_ctl_pkg::WORD_RESET, synth_ctl_pkg::WORD_RESET};
         st.pump_hiz <= 2'h3;
         st.pump_current <= {synth_ctl_pkg::PUMP_LOW, synth_ctl_pkg::PUMP_LOW};
         st.osc_buf_en <= 1'b1;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   // Sleep flags also tell the outside that counters are held
   assign o_aux_pump_up = st.pump_up[synth_ctl_pkg::AUX];
   assign o_aux_pump_dn = st.pump_dn[synth_ctl_pkg::AUX];
   assign o_aux_pump_hiz = st.pump_hiz[synth_ctl_pkg::AUX];
   assign o_aux_pump_current = st.pump_current[synth_ctl_pkg::AUX];
   assign o_main_pump_up = st.pump_up[synth_ctl_pkg::MAIN];
   assign o_main_pump_dn = st.pump_dn[synth_ctl_pkg::MAIN];
   assign o_main_pump_hiz = st.pump_hiz[synth_ctl_pkg::MAIN];
   assign o_main_pump_current = st.pump_current[synth_ctl_pkg::MAIN];
   assign o_aux_loop_sleep = st.asleep[synth_ctl_pkg::AUX];
   assign o_main_loop_sleep = st.asleep[synth_ctl_pkg::MAIN];
   assign o_osc_buf_en = st.osc_buf_en;
   assign o_mfo_out = st.mfo_out;
   assign o_mfo_oe = st.mfo_oe;

endmodule : synth_ctl

//--- pkg/synth_ctl_pkg.sv
// Constants for the dual-loop synthesizer power-down and mode control.
// Assumes a 200 MHz system clock; all serial pins are asynchronous to it.
package synth_ctl_pkg;
   // Serial word layout
   localparam int WORD_W = 22;
   localparam int DATA_W = 20;
   localparam int ADDR_W = 2;
   localparam logic [ADDR_W-1:0] ADDR_AUX_R = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_AUX_N = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_MAIN_R = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_MAIN_N = 2'h3;
   // Bit positions inside the 20-bit data field
   localparam int BIT_POLARITY = 15;
   localparam int BIT_GAIN = 16;
   localparam int BIT_HIZ = 17;
   localparam int BIT_SEL_LO = 18;
   localparam int BIT_SEL_HI = 19;
   localparam int BIT_SLEEP = 19;
   localparam int BIT_PRESCALE = 18;
   localparam int R_RATIO_W = 15;
   localparam int A_LSB = 0;
   localparam int A_W = 5;
   localparam int B_LSB = 5;
   localparam int B_W = 13;
   localparam int N_RATIO_W = 18;
   // Prescaler modulus as a shift: 16 when low, 32 when high
   localparam int P_SHIFT_LO = 4;
   localparam int P_SHIFT_HI = 5;
   // Loop indices
   localparam int AUX = 0;
   localparam int MAIN = 1;
   // Relative pump current: low is one quarter of high
   localparam logic [2:0] PUMP_LOW = 3'h1;
   localparam logic [2:0] PUMP_HIGH = 3'h4;
   // Lock window: a pump pulse no longer than this counts as locked
   localparam int CLK_MHZ = 200;
   localparam int LOCK_WINDOW_NS = 40;
   localparam int LOCK_W = 4;
   localparam logic [LOCK_W-1:0] LOCK_CYC = LOCK_W'(LOCK_WINDOW_NS * CLK_MHZ / 1000);
   localparam logic [LOCK_W-1:0] LEN_MAX = 4'hf;
   localparam logic [DATA_W-1:0] WORD_RESET = 20'h00000;
endpackage : synth_ctl_pkg
